// ===== wsit_params.svh
/*
 Bit positions and fixed values for the wiper setting I2C target.
 Assumes inclusion by bare name from the design files.
*/
`ifndef WSIT_PARAMS_SVH
`define WSIT_PARAMS_SVH
`define WSIT_WIPER_RESET   7'h40
`define WSIT_DEF_ADDR      7'h2E
`define WSIT_WIPER_MSB     6
`define WSIT_LAST_BIT      3'h7
`endif

// ===== wsit_pkg.sv
/*
 Types shared by the wiper setting I2C target.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package wsit_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_WDAT = 5'h04,
        ST_RDAT = 5'h08,
        ST_ACK  = 5'h10
    } wsit_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } wsit_pins_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic sda;
    } wsit_events_t;
endpackage

// ===== wsit_sync.sv
/*
 Two flip-flop synchroniser and edge finder for the bus pins.
 Assumes scl and sda come from outside the clk domain.
*/
`timescale 1ns/1ns
module wsit_sync (
    input  wire logic                  clk,     // System clock
    input  wire logic                  srst,    // Synchronous reset
    input  wire wsit_pkg::wsit_pins_t  pins,    // Raw bus levels
    output wsit_pkg::wsit_events_t     events   // Decoded bus events
);
    typedef struct packed {
        wsit_pkg::wsit_pins_t s1;
        wsit_pkg::wsit_pins_t s2;
        wsit_pkg::wsit_pins_t s3;
    } wsit_sync_state_t;

    wsit_sync_state_t st;
    wsit_sync_state_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (srst) begin
            next_st = '{s1: '{1'b1, 1'b1}, s2: '{1'b1, 1'b1}, s3: '{1'b1, 1'b1}};
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    always_comb begin
        events.rise  = st.s2.scl & ~st.s3.scl;
        events.fall  = ~st.s2.scl & st.s3.scl;
        events.start = st.s2.scl & st.s3.scl & st.s3.sda & ~st.s2.sda;
        events.stop  = st.s2.scl & st.s3.scl & ~st.s3.sda & st.s2.sda;
        events.sda   = st.s2.sda;
    end
endmodule

// ===== wiper_setting_i2c_target.sv
/*
 I2C target holding a 7-bit wiper code for a 128-tap resistor ladder.
 Assumes a controller on scl/sda with external pull-ups; scl stays far
 slower than clk so each bus level lasts several clk cycles.
*/
`timescale 1ns/1ns
`include "wsit_params.svh"
module wiper_setting_i2c_target #(
    parameter logic [6:0] TARGET_ADDR = `WSIT_DEF_ADDR  // Bus address of this variant
) (
    input  wire logic        clk,          // 50 MHz system clock
    input  wire logic        srst,         // Synchronous reset, active high
    input  wire logic        scl_in,       // Bus clock level
    input  wire logic        sda_in,       // Bus data level
    output logic             sda_out,      // Always 0; pin is open drain
    output logic             sda_oe,       // High while pulling SDA low
    output logic [6:0]       wiper_latch   // Tap selection for the ladder
);
    typedef struct packed {
        wsit_pkg::wsit_state_t state;
        wsit_pkg::wsit_state_t after_ack;
        logic [2:0]            bit_cnt;
        logic [7:0]            shreg;
        logic                  rd_mode;
        logic                  master_ack;
        logic                  sda_oe;
        logic [6:0]            wiper;
    } wsit_top_state_t;

    wsit_top_state_t        st;
    wsit_top_state_t        next_st;
    wsit_pkg::wsit_events_t ev;
    wsit_pkg::wsit_pins_t   bus_pins;

    assign bus_pins = '{scl: scl_in, sda: sda_in};

    wsit_sync u_sync (
        .clk    (clk),
        .srst   (srst),
        .pins   (bus_pins),
        .events (ev)
    );

    always_comb begin
        next_st = st;
        if (ev.start) begin
            next_st.state   = wsit_pkg::ST_ADDR;
            next_st.bit_cnt = 3'h0;
            next_st.sda_oe  = 1'b0;
            next_st.master_ack = 1'b0;
        end else if (ev.stop) begin
            next_st.state  = wsit_pkg::ST_IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            case (st.state)
                wsit_pkg::ST_IDLE: begin
                    next_st.sda_oe = 1'b0;
                end
                wsit_pkg::ST_ADDR, wsit_pkg::ST_WDAT: begin
                    if (ev.rise) begin
                        next_st.shreg   = {st.shreg[6:0], ev.sda};
                        next_st.bit_cnt = st.bit_cnt + 3'h1;
                    end
                    if (ev.fall && st.bit_cnt == 3'h0 && st.master_ack) begin
                        if (st.state == wsit_pkg::ST_ADDR) begin
                            if (st.shreg[7:1] == TARGET_ADDR) begin
                                next_st.sda_oe    = 1'b1;
                                next_st.rd_mode   = st.shreg[0];
                                next_st.after_ack = st.shreg[0] ? wsit_pkg::ST_RDAT
                                                                : wsit_pkg::ST_WDAT;
                                next_st.state     = wsit_pkg::ST_ACK;
                            end else begin
                                next_st.state = wsit_pkg::ST_IDLE;
                            end
                        end else begin
                            next_st.wiper     = st.shreg[`WSIT_WIPER_MSB:0];
                            next_st.sda_oe    = 1'b1;
                            next_st.after_ack = wsit_pkg::ST_WDAT;
                            next_st.state     = wsit_pkg::ST_ACK;
                        end
                    end
                    if (ev.rise) begin
                        next_st.master_ack = (st.bit_cnt == `WSIT_LAST_BIT);
                    end
                end
                wsit_pkg::ST_ACK: begin
                    // Released SDA in a read: this ninth clock is the controller's answer
                    if (ev.rise && st.rd_mode && !st.sda_oe) begin
                        next_st.master_ack = ~ev.sda;
                    end
                    if (ev.fall) begin
                        next_st.bit_cnt    = 3'h0;
                        next_st.master_ack = 1'b0;
                        if (st.after_ack == wsit_pkg::ST_RDAT) begin
                            if (st.sda_oe || st.master_ack) begin
                                next_st.state  = wsit_pkg::ST_RDAT;
                                next_st.shreg  = {1'b0, st.wiper};
                                next_st.sda_oe = 1'b1;
                            end else begin
                                next_st.state  = wsit_pkg::ST_IDLE;
                                next_st.sda_oe = 1'b0;
                            end
                        end else begin
                            next_st.state  = wsit_pkg::ST_WDAT;
                            next_st.sda_oe = 1'b0;
                        end
                    end
                end
                wsit_pkg::ST_RDAT: begin
                    if (ev.rise) begin
                        next_st.bit_cnt    = st.bit_cnt + 3'h1;
                        next_st.master_ack = (st.bit_cnt == `WSIT_LAST_BIT);
                    end
                    if (ev.fall) begin
                        if (st.master_ack) begin
                            // Eight bits out: let go of SDA for the answer bit
                            next_st.sda_oe     = 1'b0;
                            next_st.master_ack = 1'b0;
                            next_st.after_ack  = wsit_pkg::ST_RDAT;
                            next_st.state      = wsit_pkg::ST_ACK;
                        end else begin
                            next_st.shreg  = {st.shreg[6:0], 1'b0};
                            next_st.sda_oe = ~st.shreg[6];
                        end
                    end
                end
                default: begin
                    next_st.state = wsit_pkg::ST_IDLE;
                end
            endcase
        end
        if (srst) begin
            next_st.state      = wsit_pkg::ST_IDLE;
            next_st.after_ack  = wsit_pkg::ST_IDLE;
            next_st.bit_cnt    = 3'h0;
            next_st.shreg      = 8'h00;
            next_st.rd_mode    = 1'b0;
            next_st.master_ack = 1'b0;
            next_st.sda_oe     = 1'b0;
            next_st.wiper      = `WSIT_WIPER_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // Code maps straight to tap index, 0 at B end, 127 near A
    always_ff @(posedge clk) begin
        wiper_latch <= next_st.wiper;
        sda_oe      <= next_st.sda_oe;
        sda_out     <= 1'b0;
    end

    AST_RESET_MID: assert property (@(posedge clk) srst |=> wiper_latch == 7'h40)
        else $error("wiper not midscale after reset");
    AST_SDA_STABLE: assert property (@(posedge clk) disable iff (srst)
        $changed(sda_oe) |-> !scl_in)
        else $error("sda drive changed while scl high");
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (srst)
        st.state == wsit_pkg::ST_IDLE |-> !st.sda_oe)
        else $error("driving sda while idle");
    AST_STOP_IDLE: assert property (@(posedge clk) disable iff (srst)
        ev.stop |=> st.state == wsit_pkg::ST_IDLE)
        else $error("stop did not return to idle");
    AST_START_ADDR: assert property (@(posedge clk) disable iff (srst)
        ev.start |=> st.state == wsit_pkg::ST_ADDR && st.bit_cnt == 3'h0)
        else $error("start not detected");
    AST_WIPER_HOLD: assert property (@(posedge clk) disable iff (srst)
        st.state != wsit_pkg::ST_WDAT |=> $stable(st.wiper))
        else $error("wiper changed outside write");
    AST_ACK_MATCH: assert property (@(posedge clk) disable iff (srst)
        ($rose(st.sda_oe) && $past(st.state) == wsit_pkg::ST_ADDR)
        |-> $past(st.shreg[7:1]) == TARGET_ADDR)
        else $error("ack for wrong address");
    AST_OUT_FOLLOW: assert property (@(posedge clk) disable iff (srst)
        $changed(wiper_latch) |-> $past(st.state) == wsit_pkg::ST_WDAT && $past(ev.fall))
        else $error("output changed outside a data byte");

    // Address or answer acknowledged, read byte begins
    sequence seq_read_entry;
        st.state == wsit_pkg::ST_ACK ##1 st.state == wsit_pkg::ST_RDAT;
    endsequence
    AST_READ_TOP_ZERO: assert property (@(posedge clk) disable iff (srst)
        seq_read_entry |-> st.sda_oe && st.shreg[7] == 1'b0)
        else $error("read byte does not open with a zero bit");
endmodule

// ===== wsit_ctl_model.sv
/*
 Bus controller model that drives SCL and pulls SDA low for the target.
 Assumes a pull-up on SDA; the bench resolves the wire from all pull-downs.
*/
`timescale 1ns/1ns
module wsit_ctl_model (
    input  wire logic clk,      // Bench clock, paces the bus
    input  wire logic sda,      // Resolved SDA wire level
    output logic      scl,      // Bus clock, stands high between frames
    output logic      sda_low   // High while pulling SDA low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One step is 40 ns; each SCL level lasts two steps, a 160 ns period
    task automatic steps(input int n);
        repeat (n * 2) @(negedge clk);
    endtask

    task automatic bit_io(input logic b, output logic seen);
        sda_low = ~b;
        steps(1);
        scl = 1'b1;
        steps(1);
        seen = sda;
        steps(1);
        scl = 1'b0;
        steps(1);
    endtask

    task automatic start();
        sda_low = 1'b0;
        steps(1);
        scl = 1'b1;
        steps(1);
        sda_low = 1'b1;
        steps(1);
        scl = 1'b0;
        steps(1);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        steps(1);
        scl = 1'b1;
        steps(1);
        sda_low = 1'b0;
        steps(1);
    endtask

    // MSB first, then the ninth clock samples the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, ack);
    endtask

    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~more, s);
    endtask
endmodule

// ===== wiper_setting_i2c_target_bench.sv
/*
 Self-checking bench for the wiper setting target.
 Assumes the controller model above and a pull-up on the SDA wire.
*/
`timescale 1ns/1ns
module wiper_setting_i2c_target_bench;
    localparam logic [6:0] ADDR = 7'h2E;
    logic       clk;
    logic       srst;
    logic       scl;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe;
    logic [6:0] wiper_latch;
    logic       ack;
    logic [7:0] rd;
    int         err_count;
    int         n_compared;
    wire logic  sda = ~(sda_oe | sda_low);

    wiper_setting_i2c_target #(.TARGET_ADDR(ADDR)) uut (
        .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wiper_latch(wiper_latch));
    wsit_ctl_model ctl (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    always #10 clk = ~clk;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_write();
        ctl.start();
        ctl.send_byte({ADDR, 1'b0}, ack);
        chk("addr ack", 8'h00, {7'h00, ack});
        chk("sda_out", 8'h00, {7'h00, sda_out});
        ctl.send_byte(8'h80, ack);
        chk("data ack", 8'h00, {7'h00, ack});
        chk("wiper", 8'h00, {1'b0, wiper_latch});
        ctl.send_byte(8'h7F, ack);
        chk("wiper", 8'h7F, {1'b0, wiper_latch});
        ctl.stop();
        chk("wiper held", 8'h7F, {1'b0, wiper_latch});
        $display("t_write done");
    endtask

    task automatic t_read();
        ctl.start();
        ctl.send_byte({ADDR, 1'b0}, ack);
        ctl.send_byte(8'h95, ack);
        chk("wiper", 8'h15, {1'b0, wiper_latch});
        ctl.start();
        ctl.send_byte({ADDR, 1'b1}, ack);
        chk("read ack", 8'h00, {7'h00, ack});
        ctl.recv_byte(1'b1, rd);
        chk("read 1", 8'h15, rd);
        ctl.recv_byte(1'b0, rd);
        chk("read 2", 8'h15, rd);
        ctl.stop();
        $display("t_read done");
    endtask

    task automatic t_foreign();
        ctl.start();
        ctl.send_byte({ADDR ^ 7'h01, 1'b0}, ack);
        chk("foreign ack", 8'h01, {7'h00, ack});
        ctl.send_byte(8'h22, ack);
        chk("foreign data ack", 8'h01, {7'h00, ack});
        ctl.stop();
        chk("wiper kept", 8'h15, {1'b0, wiper_latch});
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk("wiper reset", 8'h40, {1'b0, wiper_latch});
        repeat (4) @(negedge clk);
        $display("t_foreign done");
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        end_sim();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        err_count = 0;
        n_compared = 0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        chk("wiper reset", 8'h40, {1'b0, wiper_latch});
        t_write();
        t_read();
        t_foreign();
        end_sim();
    end
endmodule
